/* File: hdl/clg_pkg.sv */
package clg_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS   = 50;          // 20 MHz system clock
  localparam int unsigned TICK_NS  = 100_000_000; // 100 ms time base
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NGATE = 4;
  localparam int unsigned NIN   = 4;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STAT   = 12'h004;
  localparam logic [11:0] ADDR_GATE0  = 12'h010;
  localparam logic [11:0] ADDR_GEND   = 12'h050;
  localparam logic [1:0]  REG_CFG     = 2'h0;
  localparam logic [1:0]  REG_SRC     = 2'h1;
  localparam logic [1:0]  REG_TIME    = 2'h2;
  localparam logic [1:0]  REG_VAL     = 2'h3;
  localparam logic [2:0]  CNT_RST     = 3'h0;
  localparam logic [2:0]  CNT_MAX     = 3'h4;
  localparam logic [31:0] REG_RST     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned B_OP   = 0;
  localparam int unsigned B_NIN  = 2;
  localparam int unsigned B_INV  = 4;
  localparam int unsigned B_FMT  = 8;
  localparam int unsigned B_OINV = 10;
  localparam int unsigned B_TRG  = 11;
  localparam int unsigned B_CMD0 = 13;
  localparam int unsigned B_CMD1 = 14;
  localparam int unsigned B_ON   = 0;
  localparam int unsigned B_OFF  = 8;
  localparam int unsigned B_CYC  = 16;
  localparam int unsigned B_VAL0 = 0;
  localparam int unsigned B_VAL1 = 8;

  // ---------------------------------------------------------------
  // input source codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SRC_EXT   = 4'h0;
  localparam logic [3:0] SRC_LIM0  = 4'h1;
  localparam logic [3:0] SRC_DEW   = 4'h5;
  localparam logic [3:0] SRC_GATE0 = 4'h8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_AND   = 2'b00,
    OP_OR    = 2'b01,
    OP_XOR   = 2'b10,
    OP_ANDFB = 2'b11
  } clg_op_e;

  typedef enum logic [1:0] {
    TRG_EVENT  = 2'b00,
    TRG_CHANGE = 2'b01,
    TRG_CYCLIC = 2'b10,
    TRG_RSVD   = 2'b11
  } clg_trg_e;

  typedef enum logic [1:0] {
    FMT_BIT  = 2'b00,
    FMT_BYTE = 2'b01,
    FMT_BOTH = 2'b10,
    FMT_RSVD = 2'b11
  } clg_fmt_e;

  typedef struct packed {
    clg_op_e     op;
    logic [1:0]  nin_m1;
    logic [3:0]  inv;
    clg_trg_e    trg;
    logic [7:0]  on_dly;
    logic [7:0]  off_dly;
    logic [15:0] cyc;
  } clg_cfg_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] gate;
    logic [1:0] input_no;
    logic       value;
  } clg_rx_s;

  typedef struct packed {
    logic [1:0] gate;
    logic       obj;
    logic       is_byte;
    logic [7:0] data;
  } clg_tx_s;

endpackage : clg_pkg

/* File: hdl/clg_gate.sv */
`timescale 1ns/100ps
module clg_gate (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // control
  input  wire logic             tick,
  input  wire logic             en,
  input  wire clg_pkg::clg_cfg_s cfg,
  // input events and values
  input  wire logic [3:0]       ev,
  input  wire logic [3:0]       val,
  // state and send request
  output logic                  res,
  output logic [3:0]            ins,
  output logic                  send
);

  logic [3:0]  in_ff;
  logic        res_ff;
  logic        pend_ff;
  logic [7:0]  tmr_ff;
  logic [15:0] cyc_ff;
  logic [3:0]  nin;
  logic        any_ev;
  logic        any_one;
  logic        r_ev;
  logic [7:0]  dly;
  logic        load;
  logic        expire;
  logic        commit;
  logic        cyc_hit;

  // logic operation over the used inputs
  function automatic logic f_eval(input logic [3:0] v,
                                  input clg_pkg::clg_cfg_s c);
    logic [3:0] e;
    logic [3:0] m;
    logic       r;
    e = v ^ c.inv;
    m = 4'hf >> (2'h3 - c.nin_m1);
    unique case (c.op)
      clg_pkg::OP_AND:   r = &(e | ~m);
      clg_pkg::OP_OR:    r = |(e & m);
      clg_pkg::OP_XOR:   r = ^(e & m);
      clg_pkg::OP_ANDFB: r = &(e | ~m);
    endcase
    return r;
  endfunction : f_eval

  // new inputs, result and delay decisions
  always_comb
  begin
    nin     = (in_ff & ~ev) | (val & ev);
    any_ev  = en & (|ev);
    any_one = |(ev & val);
    r_ev    = f_eval(nin, cfg);
    dly     = r_ev ? cfg.on_dly : cfg.off_dly;
    load    = any_ev & (~pend_ff | ~r_ev | any_one);
    expire  = en & tick & pend_ff & (tmr_ff == 8'h01);
    commit  = (load & (dly == 8'h00)) | (expire & ~load);
    cyc_hit = en & tick & (cfg.cyc != 16'h0000)
              & (cyc_ff == cfg.cyc - 16'h0001);
  end

  // input store, input 1 follows the output in feedback mode
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      in_ff <= 4'h0;
    else if (en)
    begin
      in_ff <= nin;
      if (commit && cfg.op == clg_pkg::OP_ANDFB)
        in_ff[0] <= r_ev;
    end
  end

  // committed result
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      res_ff <= 1'b0;
    else if (commit)
      res_ff <= r_ev;
  end

  // retriggerable on/off delay
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_ff <= 1'b0;
      tmr_ff  <= 8'h00;
    end
    else if (!en || (load && dly == 8'h00) || (expire && !load))
    begin
      pend_ff <= 1'b0;
      tmr_ff  <= 8'h00;
    end
    else if (load)
    begin
      pend_ff <= 1'b1;
      tmr_ff  <= dly;
    end
    else if (tick && pend_ff)
      tmr_ff <= tmr_ff - 8'h01;
  end

  // cyclic repeat counter in time-base ticks
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cyc_ff <= 16'h0000;
    else if (!en || cfg.cyc == 16'h0000)
      cyc_ff <= 16'h0000;
    else if (tick)
      cyc_ff <= cyc_hit ? 16'h0000 : cyc_ff + 16'h0001;
  end

  // send request: event, change or cyclic
  always_comb
  begin
    send = cyc_hit;
    if (commit && cfg.trg == clg_pkg::TRG_EVENT)
      send = 1'b1;
    if (commit && cfg.trg == clg_pkg::TRG_CHANGE && r_ev != res_ff)
      send = 1'b1;
  end

  assign res = res_ff;
  assign ins = in_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_expire;
    tick && pend_ff && tmr_ff == 8'h01 && en && !any_ev;
  endsequence

  a_only_on_event: assert property ($changed(res_ff) |->
    $past(any_ev) || $past(expire))
    else $error("result changed without event or expiry");
  a_delay_expire: assert property (s_expire |=>
    !pend_ff && res_ff == $past(r_ev))
    else $error("delay expiry did not commit");
  a_on_restart: assert property (load && r_ev
    && cfg.on_dly != 8'h00 |=> pend_ff && tmr_ff == $past(cfg.on_dly))
    else $error("switch-on delay not restarted");
  a_fb_input1: assert property (commit
    && cfg.op == clg_pkg::OP_ANDFB |=> in_ff[0] == res_ff)
    else $error("feedback input 1 not following output");
  a_or_zero: assert property (commit && cfg.op == clg_pkg::OP_OR
    && ((nin ^ cfg.inv) & (4'hf >> (2'h3 - cfg.nin_m1))) == 4'h0
    |=> !res_ff)
    else $error("or gate gave one with no active input");
  a_cyc_send: assert property (cyc_hit |-> send ##1
    cyc_ff == 16'h0000)
    else $error("cyclic send missing");

endmodule : clg_gate

/* File: hdl/clg_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - four gates, each with one to four inputs
// - gates in use configurable, at most four
// - operation: AND, OR, XOR, AND with feedback
// - each input normal or inverted before operation
// - output object 1-bit or 1-byte, bit invertible
// - output count and format chosen per gate
// - input from external object or internal bit
// - send on input event, output change, cyclic
// - evaluate only when an input telegram arrives; an internal bit change also triggers evaluation
// - feedback mode: output drives input 1
// - feedback loops allowed, disturb nothing else
// - delays retrigger on 1 input or 0 output
// - evaluate and send only after delay expires
// - optional cyclic retransmission at set interval
// - configurable command or byte per logic level
module clg_top #(
  parameter int unsigned TICK_CYC = clg_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              NRST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // received input telegrams and internal sources
  input  wire clg_pkg::clg_rx_s  RX_MSG,
  input  wire logic [3:0]        LIMIT,
  input  wire logic              DEW_ALARM,
  // output telegrams
  output logic                   TX_VALID,
  input  wire logic              TX_READY,
  output clg_pkg::clg_tx_s       TX_MSG
);

  if (TICK_CYC < 1 || TICK_CYC > 32'h7fff_ffff)
    $error("TICK_CYC out of range");

  logic [31:0]       reg_ff [4][4];
  logic [2:0]        cnt_ff;
  logic [31:0]       rd_ff;
  logic [31:0]       tick_ff;
  logic              tick;
  logic [8:0]        int_v;
  logic [8:0]        int_prev_ff;
  logic [3:0]        res;
  logic [3:0]        lvl;
  logic [3:0]        en;
  logic [3:0]        send;
  logic [15:0]       ins;
  logic [7:0]        pend_ff;
  logic [7:0]        pend_set;
  logic              tx_vld_ff;
  clg_pkg::clg_tx_s  tx_ff;
  clg_pkg::clg_cfg_s cfg [4];
  logic [11:0]       goff;
  logic              g_hit;
  logic              hit;
  logic [1:0]        gi;
  logic [1:0]        ri;
  logic              wr;
  logic              load;
  logic [2:0]        pick;
  logic [31:0]       wd;
  logic [1:0]        cmd;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // gate block is four words per gate from the gate base
  always_comb
  begin
    goff  = PADDR - clg_pkg::ADDR_GATE0;
    g_hit = PADDR >= clg_pkg::ADDR_GATE0 && PADDR < clg_pkg::ADDR_GEND
            && PADDR[1:0] == 2'b00;
    hit   = g_hit || PADDR == clg_pkg::ADDR_CTRL
            || PADDR == clg_pkg::ADDR_STAT;
    gi    = goff[5:4];
    ri    = goff[3:2];
    wr    = PSEL && PENABLE && PWRITE;
  end

  // zero wait state, error on unmapped address
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign PRDATA  = rd_ff;

  // number of gates in use, clipped to four
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      cnt_ff <= clg_pkg::CNT_RST;
    else if (wr && PADDR == clg_pkg::ADDR_CTRL)
      cnt_ff <= (PWDATA[2:0] > clg_pkg::CNT_MAX) ? clg_pkg::CNT_MAX
                                                 : PWDATA[2:0];
  end

  // per gate configuration words
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int g = 0; g < 4; g++)
        for (int r = 0; r < 4; r++)
          reg_ff[g][r] <= clg_pkg::REG_RST;
    end
    else if (wr && g_hit)
      reg_ff[gi][ri] <= PWDATA;
  end

  // read data captured in the setup phase
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      rd_ff <= 32'h0000_0000;
    else if (PSEL && !PENABLE)
    begin
      if (g_hit)
        rd_ff <= reg_ff[gi][ri];
      else if (PADDR == clg_pkg::ADDR_CTRL)
        rd_ff <= {29'h0, cnt_ff};
      else if (PADDR == clg_pkg::ADDR_STAT)
        rd_ff <= {4'h0, pend_ff, ins, res};
      else
        rd_ff <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  // one-cycle enable every time-base period
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      tick_ff <= 32'h0000_0000;
    else if (tick)
      tick_ff <= 32'h0000_0000;
    else
      tick_ff <= tick_ff + 32'h0000_0001;
  end

  assign tick = (tick_ff == TICK_CYC - 1);

  // ---------------------------------------------------------------
  // internal sources
  // ---------------------------------------------------------------
  // registered copy holds the previous values for internal bit change detection
  assign int_v = {lvl, DEW_ALARM, LIMIT};

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      int_prev_ff <= 9'h000;
    else
      int_prev_ff <= int_v;
  end

  // value of an internal source by its code
  function automatic logic f_src(input logic [3:0] c,
                                 input logic [8:0] v);
    logic b;
    b = 1'b0;
    if (c >= clg_pkg::SRC_LIM0 && c <= clg_pkg::SRC_DEW)
      b = v[c - clg_pkg::SRC_LIM0];
    else if (c >= clg_pkg::SRC_GATE0)
      b = (c < clg_pkg::SRC_GATE0 + 4'h4) ? v[c - 4'h3] : 1'b0;
    return b;
  endfunction : f_src

  // ---------------------------------------------------------------
  // gates
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 4; g++)
  begin : gen_gate
    logic [3:0] ev;
    logic [3:0] val;
    logic [1:0] fmt;

    assign en[g]   = 3'(g) < cnt_ff;
    assign fmt     = reg_ff[g][clg_pkg::REG_CFG][clg_pkg::B_FMT +: 2];
    assign lvl[g]  = res[g] ^ reg_ff[g][clg_pkg::REG_CFG][clg_pkg::B_OINV];
    assign cfg[g]  = '{
      op:      clg_pkg::clg_op_e'(
               reg_ff[g][clg_pkg::REG_CFG][clg_pkg::B_OP +: 2]),
      nin_m1:  reg_ff[g][clg_pkg::REG_CFG][clg_pkg::B_NIN +: 2],
      inv:     reg_ff[g][clg_pkg::REG_CFG][clg_pkg::B_INV +: 4],
      trg:     clg_pkg::clg_trg_e'(
               reg_ff[g][clg_pkg::REG_CFG][clg_pkg::B_TRG +: 2]),
      on_dly:  reg_ff[g][clg_pkg::REG_TIME][clg_pkg::B_ON +: 8],
      off_dly: reg_ff[g][clg_pkg::REG_TIME][clg_pkg::B_OFF +: 8],
      cyc:     reg_ff[g][clg_pkg::REG_TIME][clg_pkg::B_CYC +: 16]};

    // route external telegram or internal bit change to each input
    for (genvar i = 0; i < 4; i++)
    begin : gen_in
      logic [3:0] sc;
      assign sc = reg_ff[g][clg_pkg::REG_SRC][4*i +: 4];
      assign ev[i] = (sc == clg_pkg::SRC_EXT)
        ? (RX_MSG.valid && RX_MSG.gate == 2'(g)
           && RX_MSG.input_no == 2'(i))
        : (f_src(sc, int_v) != f_src(sc, int_prev_ff));
      assign val[i] = (sc == clg_pkg::SRC_EXT) ? RX_MSG.value
                                               : f_src(sc, int_v);
    end

    // second object only in the bit-plus-byte format
    assign pend_set[2*g]   = send[g];
    assign pend_set[2*g+1] = send[g] && fmt == clg_pkg::FMT_BOTH;

    clg_gate u_gate (
      .clk  (CLK),
      .nrst (NRST),
      .tick (tick),
      .en   (en[g]),
      .cfg  (cfg[g]),
      .ev   (ev),
      .val  (val),
      .res  (res[g]),
      .ins  (ins[4*g +: 4]),
      .send (send[g])
    );
  end

  // ---------------------------------------------------------------
  // output telegrams
  // ---------------------------------------------------------------
  // lowest pending object goes out first
  always_comb
  begin
    pick = 3'h0;
    for (int p = 7; p >= 0; p--)
      if (pend_ff[p])
        pick = 3'(p);
    load = (|pend_ff) && (!tx_vld_ff || TX_READY);
    wd   = f_word(pick);
    cmd  = f_cmd(pick);
  end

  // pending objects; a new request wins over the clear
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      pend_ff <= 8'h00;
    else
      pend_ff <= (pend_ff & ~(load ? (8'h01 << pick) : 8'h00))
                 | pend_set;
  end

  // valid held until the bus takes the telegram
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      tx_vld_ff <= 1'b0;
    else if (load)
      tx_vld_ff <= 1'b1;
    else if (TX_READY)
      tx_vld_ff <= 1'b0;
  end

  // object contents by format and logic level
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      tx_ff <= '0;
    else if (load)
    begin
      tx_ff.gate    <= pick[2:1];
      tx_ff.obj     <= pick[0];
      tx_ff.is_byte <= f_byte(pick);
      tx_ff.data    <= f_byte(pick)
        ? (res[pick[2:1]] ? wd[clg_pkg::B_VAL1 +: 8]
                          : wd[clg_pkg::B_VAL0 +: 8])
        : {7'h00, lvl[pick[2:1]] ? cmd[1] : cmd[0]};
    end
  end

  // whether an object is the byte object of its gate
  function automatic logic f_byte(input logic [2:0] p);
    logic [1:0] f;
    f = reg_ff[p[2:1]][clg_pkg::REG_CFG][clg_pkg::B_FMT +: 2];
    return f == clg_pkg::FMT_BYTE || (f == clg_pkg::FMT_BOTH && p[0]);
  endfunction : f_byte

  // byte values word of a gate
  function automatic logic [31:0] f_word(input logic [2:0] p);
    return reg_ff[p[2:1]][clg_pkg::REG_VAL];
  endfunction : f_word

  // switching commands {for 1, for 0} of a gate
  function automatic logic [1:0] f_cmd(input logic [2:0] p);
    return {reg_ff[p[2:1]][clg_pkg::REG_CFG][clg_pkg::B_CMD1],
            reg_ff[p[2:1]][clg_pkg::REG_CFG][clg_pkg::B_CMD0]};
  endfunction : f_cmd

  assign TX_VALID = tx_vld_ff;
  assign TX_MSG   = tx_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  a_tx_hold: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_MSG))
    else $error("telegram changed before it was taken");
  a_unmapped_err: assert property (PSEL && PENABLE && !hit |->
    PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access without error");
  a_count_limit: assert property (wr && PADDR == clg_pkg::ADDR_CTRL
    |=> cnt_ff <= clg_pkg::CNT_MAX)
    else $error("gate count above four");
  a_send_queued: assert property (send[0] |=> pend_ff[0] || TX_VALID)
    else $error("send request lost");

endmodule : clg_top

/* File: bench/clg_bus_model.sv */
`timescale 1ns/100ps
// ---------------------------------------------
// far side of the telegram link
// ---------------------------------------------
module clg_bus_model (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // telegram link
  input  wire logic             tx_valid,
  input  wire clg_pkg::clg_tx_s tx_msg,
  output logic                  tx_ready,
  // control and capture
  input  wire logic             slow,
  output logic                  got,
  output clg_pkg::clg_tx_s      msg
);
  logic rdy_ff;

  // slow mode accepts only every other cycle
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      rdy_ff <= 1'b0;
    else
      rdy_ff <= slow ? !rdy_ff : 1'b1;

  assign tx_ready = rdy_ff;

  // hand each accepted telegram to the bench
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      got <= 1'b0;
      msg <= '0;
    end
    else
    begin
      got <= tx_valid & rdy_ff;
      msg <= tx_msg;
    end
endmodule : clg_bus_model

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
// ---------------------------------------------
// gate array bench
// ---------------------------------------------
module tb_top;
  logic             clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic             tx_valid, tx_ready, got, dew, err, slow;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [3:0]       limit;
  clg_pkg::clg_rx_s rx;
  clg_pkg::clg_tx_s tx_msg, msg;
  clg_pkg::clg_tx_s q[$];
  int               miscompares, total_checks;

  clg_top #(.TICK_CYC(10)) clg_top_i (
    .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_MSG(rx), .LIMIT(limit),
    .DEW_ALARM(dew), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_MSG(tx_msg));

  clg_bus_model clg_bus_model_i (
    .clk(clk), .nrst(nrst), .tx_valid(tx_valid), .tx_msg(tx_msg),
    .tx_ready(tx_ready), .slow(slow), .got(got), .msg(msg));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // collect accepted telegrams
  always @(posedge clk)
    if (got === 1'b1)
      q.push_back(msg);

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // configure gate 0 and drop stray telegrams
  task gcfg(input logic [31:0] c, s, t, v);
    apb(1'b1, clg_pkg::ADDR_GATE0, c);
    apb(1'b1, clg_pkg::ADDR_GATE0 + 12'h4, s);
    apb(1'b1, clg_pkg::ADDR_GATE0 + 12'h8, t);
    apb(1'b1, clg_pkg::ADDR_GATE0 + 12'hc, v);
    repeat (6) @(posedge clk);
    q.delete();
  endtask : gcfg

  // one input telegram, to gate 0 unless given
  task tel(input logic [1:0] n, input logic v,
           input logic [1:0] g = 2'd0);
    @(posedge clk);
    rx <= {1'b1, g, n, v};
    @(posedge clk);
    rx <= '0;
  endtask : tel

  // wait for a telegram and judge it
  task exp_tx(input logic b, input logic [7:0] e,
              input logic [2:0] go = 3'h0);
    clg_pkg::clg_tx_s m;
    for (int i = 0; i < 60 && q.size() == 0; i++) @(posedge clk);
    if (q.size() == 0)
      chk("tx count", 32'h1, 32'h0);
    else
    begin
      m = q.pop_front();
      if (b)
        chk("tx byte", 32'({go, 1'b1, e}), 32'({m[11:8], m.data}));
      else
        chk("tx bit", 32'({go, 1'b0, e[0]}), 32'({m[11:8], m.data[0]}));
    end
  endtask : exp_tx

  task t_regs;
    apb(1'b0, clg_pkg::ADDR_CTRL, '0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b1, clg_pkg::ADDR_CTRL, 32'h7);
    apb(1'b0, clg_pkg::ADDR_CTRL, '0);
    chk("ctrl clamp", 32'h4, rd);
    apb(1'b0, 12'h0f0, '0);
    chk("unmapped", 32'h1, 32'(err));
    apb(1'b0, clg_pkg::ADDR_GATE0 + 12'h8, '0);
    chk("time reset", clg_pkg::REG_RST, rd);
  endtask : t_regs

  // AND, OR and XOR, input 2 inverted, link stalling
  task t_ops;
    slow <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      tel(2'd0, 1'b0);                         // inputs back to zero
      tel(2'd1, 1'b0);
      gcfg(32'h124 | k, 32'h0, 32'h0, 32'hc33c);
      tel(2'd0, 1'b1);
      exp_tx(1'b1, (k != 2) ? 8'hc3 : 8'h3c);
      tel(2'd1, 1'b1);
      exp_tx(1'b1, (k != 0) ? 8'hc3 : 8'h3c);
    end
    slow <= 1'b0;
  endtask : t_ops

  task t_bit;
    gcfg(32'h2401, 32'h0, 32'h0, 32'h0);
    tel(2'd0, 1'b1);
    exp_tx(1'b0, 8'h1);
    tel(2'd0, 1'b0);
    exp_tx(1'b0, 8'h0);
  endtask : t_bit

  task t_fb;
    gcfg(32'h107, 32'h0, 32'h0, 32'hc33c);
    tel(2'd1, 1'b0);
    exp_tx(1'b1, 8'h3c);
    tel(2'd1, 1'b1);
    exp_tx(1'b1, 8'h3c);
    tel(2'd0, 1'b1);
    exp_tx(1'b1, 8'hc3);
    tel(2'd1, 1'b0);
    exp_tx(1'b1, 8'h3c);
    apb(1'b0, clg_pkg::ADDR_STAT, '0);
    chk("fed back input", 32'h0, 32'(rd[4]));
    tel(2'd1, 1'b1);
    exp_tx(1'b1, 8'h3c);
  endtask : t_fb

  // on delay of 3 ticks, restarted by a repeated 1 input
  task t_dly;
    gcfg(32'h101, 32'h0, 32'h3, 32'hc33c);
    tel(2'd0, 1'b0);
    exp_tx(1'b1, 8'h3c);
    tel(2'd0, 1'b1);
    repeat (18) @(posedge clk);
    tel(2'd0, 1'b1);
    repeat (15) @(posedge clk);
    chk("early tx", 32'h0, q.size());
    exp_tx(1'b1, 8'hc3);
  endtask : t_dly

  task t_lim;
    gcfg(32'h101, 32'h1, 32'h0, 32'hc33c);
    limit <= 4'h1;
    exp_tx(1'b1, 8'hc3);
    limit <= 4'h0;
    exp_tx(1'b1, 8'h3c);
  endtask : t_lim

  // gate 1: or of gate 0 level and a telegram, bit plus byte, on change
  task t_chg;
    apb(1'b1, clg_pkg::ADDR_GATE0 + 12'h10, 32'h4a05);
    apb(1'b1, clg_pkg::ADDR_GATE0 + 12'h14, 32'h8);
    apb(1'b1, clg_pkg::ADDR_GATE0 + 12'h1c, 32'h5aa5);
    limit <= 4'h1;
    exp_tx(1'b1, 8'hc3);
    exp_tx(1'b0, 8'h1, 3'h2);
    exp_tx(1'b1, 8'h5a, 3'h3);
    tel(2'd1, 1'b1, 2'd1);
    repeat (20) @(posedge clk);
    chk("change only", 32'h0, q.size());
    apb(1'b1, clg_pkg::ADDR_GATE0 + 12'h18, 32'h0002_0000);
    exp_tx(1'b0, 8'h1, 3'h2);
    exp_tx(1'b1, 8'h5a, 3'h3);
    apb(1'b1, clg_pkg::ADDR_GATE0 + 12'h18, 32'h0);
  endtask : t_chg

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // main sequence
  initial
  begin
    nrst = 1'b0;
    {psel, penable, pwrite, dew, slow} = '0;
    paddr = '0;
    pwdata = '0;
    rx = '0;
    limit = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_ops;
    t_bit;
    t_fb;
    t_dly;
    t_lim;
    t_chg;
    close_out;
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out;
  end
endmodule : tb_top
